// >>> verilog/bfp_pkg.sv
// Purpose: Shared constants and types for the ballast fault protection manager
// Assumes: 25 MHz system clock
// Notes: Mode encoding is one-hot as the sequencer presents it
`default_nettype none
package bfp_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned T_FILT_NS = 200;       // Short comparator filter
  localparam int unsigned T_OC_NS = 500;         // Inverter overcurrent
  localparam int unsigned T_CAP2_US = 620;       // Below-resonance operation
  localparam int unsigned T_IGN_MS = 237;        // Ignition timeout
  localparam int unsigned T_EOL_MS = 2500;       // Rectification / idling
  localparam int unsigned T_CLR_S = 40;          // Latch clear in run
  localparam int unsigned T_AR_MS = 200;         // Auto restart delay
  localparam int unsigned T_TICK_US = 1;         // Slow timer tick
  // Cycle counts; qualification times round up
  localparam int unsigned N_FILT = (T_FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned N_OC = (T_OC_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned N_TICK = T_TICK_US * (CLK_HZ / 1000000);
  // Counts in microsecond ticks
  localparam int unsigned K_CAP2 = T_CAP2_US;
  localparam int unsigned K_IGN = T_IGN_MS * 1000;
  localparam int unsigned K_EOL = T_EOL_MS * 1000;
  localparam int unsigned K_CLR = T_CLR_S * 1000000;
  localparam int unsigned K_AR = T_AR_MS * 1000;
  localparam int unsigned TW = 32;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    MODE_STARTUP  = 7'h01,
    MODE_SOFT     = 7'h02,
    MODE_PREHEAT  = 7'h04,
    MODE_IGNITION = 7'h08,
    MODE_PRERUN   = 7'h10,
    MODE_RUN      = 7'h20,
    MODE_OFF      = 7'h40
  } bfp_mode_t;
  typedef enum logic [3:0] {
    ST_ACTIVE = 4'h1,
    ST_RESTART = 4'h2,
    ST_LATCHED = 4'h4,
    ST_SURGE = 4'h8
  } bfp_state_t;
  // Comparator flags from analog front end
  typedef struct packed {
    logic lamp_rectification_fault;
    logic cap_idle;
    logic below_resonance;
    logic run_freq_reached;
    logic pfc_current_sense;
    logic inv_cs_low;     // Inverter current above 0.8 V
    logic inv_cs_high;    // Inverter current above 1.6 V
    logic bus_voltage_high;  // Bus above 109 %
  } bfp_cmp_t;
  localparam int unsigned CMP_W = 8;
endpackage
`default_nettype wire

// >>> verilog/bfp_qual_timer.sv
// Purpose: Qualification timer, fires once a condition has held long enough
// Assumes: cond is already synchronised; tick is a one-cycle enable
// Notes: Count restarts from zero whenever cond drops
`default_nettype none
module bfp_qual_timer #(
  parameter int unsigned LIMIT = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic cond,
  output logic hit
);
  logic [bfp_pkg::TW-1:0] cnt;
  logic [bfp_pkg::TW-1:0] next_cnt;
  logic next_hit;
  // Terminal count held at the counter width so the compare needs no slicing
  localparam logic [bfp_pkg::TW-1:0] LAST_CNT = LIMIT - 1;

  // Count ticks while condition persists, clear otherwise
  always_comb begin
    next_cnt = cnt;
    next_hit = 1'b0;
    if (!cond) begin
      next_cnt = '0;
    end else if (cnt >= LAST_CNT) begin
      if (tick) begin
        next_hit = 1'b1;
      end
    end else if (tick) begin
      next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt <= '0;
      hit <= 1'b0;
    end else begin
      cnt <= next_cnt;
      hit <= next_hit;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/bfp_top.sv
// Purpose: Fault qualification and reaction for a lamp ballast controller
// Assumes: Comparator flags arrive asynchronously; mode comes from the sequencer
// Notes: Timers qualify per mode; one restart then latch
//
// Overview of operation
// - Run: lamp rectification or idling for 2500 ms powers down, one restart.
// - Run: below-resonance for 620 us powers down, one restart.
// - Ignition: no run frequency within 237 ms flags timeout, powers down.
// - Start-up to run: PFC current over 1.0 V for 200 ns ends on-time.
// - Ignition: inverter current over 0.8 V for 200 ns enables ignition loop.
// - Inverter current over threshold 500 ns: fault; 0.8 V preheat/run, else 1.6 V.
// - Pre-run/run: current plus bus high 500 ns: unlatched down, restart below 109%.
// - First fault restarts once; second before clear latches powered down.
// - 40 s continuous run clears fault_once, re-arming the one restart; latched_fault holds until reset.
// - Auto-restart faults retry once after an internal delay.
`default_nettype none
module bfp_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [6:0] mode,
  input wire logic [bfp_pkg::CMP_W-1:0] cmp_in,
  output logic power_down,
  output logic restart_req,
  output logic latched_fault,
  output logic ignition_timeout,
  output logic pfc_off,
  output logic ignition_ctrl,
  output logic fault_once
);
  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [bfp_pkg::CMP_W-1:0] sync_a;
  logic [bfp_pkg::CMP_W-1:0] sync_b;
  bfp_pkg::bfp_cmp_t c;

  // Two flops before any logic reads the pins
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= cmp_in;
      sync_b <= sync_a;
    end
  end
  assign c = bfp_pkg::bfp_cmp_t'(sync_b);

  // ---------------------------------------------------------------
  // Microsecond tick divider
  // ---------------------------------------------------------------
  logic [7:0] div;
  logic [7:0] next_div;
  logic tick;
  logic next_tick;

  always_comb begin
    next_div = div + 8'h01;
    next_tick = 1'b0;
    if (div == 8'(bfp_pkg::N_TICK - 1)) begin
      next_div = 8'h00;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      div <= 8'h00;
      tick <= 1'b0;
    end else begin
      div <= next_div;
      tick <= next_tick;
    end
  end

  // ---------------------------------------------------------------
  // Mode decode and qualification conditions
  // ---------------------------------------------------------------
  logic m_run, m_ign, m_pre, m_prerun, m_active;
  bfp_pkg::bfp_state_t st, next_st;
  logic alive;
  logic cond_eol, cond_cap2, cond_ign, cond_pfc, cond_ilim, cond_oc, cond_surge;

  assign alive = (st == bfp_pkg::ST_ACTIVE);
  assign m_run = alive && (mode == bfp_pkg::MODE_RUN);
  assign m_ign = alive && (mode == bfp_pkg::MODE_IGNITION);
  assign m_pre = alive && (mode == bfp_pkg::MODE_PREHEAT);
  assign m_prerun = alive && (mode == bfp_pkg::MODE_PRERUN);
  assign m_active = alive && (mode != bfp_pkg::MODE_OFF);
  assign cond_eol = m_run && (c.lamp_rectification_fault || c.cap_idle);
  assign cond_cap2 = m_run && c.below_resonance;
  assign cond_ign = m_ign && !c.run_freq_reached;
  assign cond_pfc = m_active && c.pfc_current_sense;
  assign cond_ilim = m_ign && c.inv_cs_low;
  // Low threshold only in preheat and run; high threshold elsewhere
  assign cond_oc = ((m_pre || m_run) && c.inv_cs_low)
                || (m_active && !m_pre && !m_run && c.inv_cs_high);
  assign cond_surge = (m_prerun || m_run) && c.inv_cs_low && c.bus_voltage_high;

  // ---------------------------------------------------------------
  // Qualification timers
  // ---------------------------------------------------------------
  logic hit_eol, hit_cap2, hit_ign, hit_pfc, hit_ilim, hit_oc, hit_surge, hit_clr, hit_ar;
  logic cond_clr, cond_ar;

  // Slow timers use the microsecond tick, fast ones every cycle
  bfp_qual_timer #(.LIMIT(bfp_pkg::K_EOL)) u_eol (
    .clk(clk), .resetn(resetn), .tick(tick), .cond(cond_eol), .hit(hit_eol));
  bfp_qual_timer #(.LIMIT(bfp_pkg::K_CAP2)) u_cap2 (
    .clk(clk), .resetn(resetn), .tick(tick), .cond(cond_cap2), .hit(hit_cap2));
  bfp_qual_timer #(.LIMIT(bfp_pkg::K_IGN)) u_ign (
    .clk(clk), .resetn(resetn), .tick(tick), .cond(cond_ign), .hit(hit_ign));
  bfp_qual_timer #(.LIMIT(bfp_pkg::N_FILT)) u_pfc (
    .clk(clk), .resetn(resetn), .tick(1'b1), .cond(cond_pfc), .hit(hit_pfc));
  bfp_qual_timer #(.LIMIT(bfp_pkg::N_FILT)) u_ilim (
    .clk(clk), .resetn(resetn), .tick(1'b1), .cond(cond_ilim), .hit(hit_ilim));
  bfp_qual_timer #(.LIMIT(bfp_pkg::N_OC)) u_oc (
    .clk(clk), .resetn(resetn), .tick(1'b1), .cond(cond_oc), .hit(hit_oc));
  bfp_qual_timer #(.LIMIT(bfp_pkg::N_OC)) u_surge (
    .clk(clk), .resetn(resetn), .tick(1'b1), .cond(cond_surge), .hit(hit_surge));
  bfp_qual_timer #(.LIMIT(bfp_pkg::K_CLR)) u_clr (
    .clk(clk), .resetn(resetn), .tick(tick), .cond(cond_clr), .hit(hit_clr));
  bfp_qual_timer #(.LIMIT(bfp_pkg::K_AR)) u_ar (
    .clk(clk), .resetn(resetn), .tick(tick), .cond(cond_ar), .hit(hit_ar));

  assign cond_clr = m_run && fault_once;
  assign cond_ar = (st == bfp_pkg::ST_RESTART);

  // ---------------------------------------------------------------
  // Reaction state machine
  // ---------------------------------------------------------------
  logic f_fault;
  logic next_power_down, next_restart_req, next_latched, next_ign_to;
  logic next_pfc_off, next_ign_ctrl, next_fault_once;

  // Surge outranks ordinary faults because it must not consume the restart
  assign f_fault = hit_eol || hit_cap2 || hit_ign || hit_oc;

  always_comb begin
    next_st = st;
    next_power_down = power_down;
    next_restart_req = 1'b0;
    next_latched = latched_fault;
    next_ign_to = ignition_timeout;
    next_fault_once = fault_once;
    next_pfc_off = hit_pfc;
    next_ign_ctrl = hit_ilim || (ignition_ctrl && cond_ilim);
    case (st)
      bfp_pkg::ST_ACTIVE: begin
        if (hit_surge) begin
          next_st = bfp_pkg::ST_SURGE;
          next_power_down = 1'b1;
        end else if (f_fault) begin
          next_power_down = 1'b1;
          if (hit_ign) begin
            next_ign_to = 1'b1;
          end
          if (fault_once) begin
            next_st = bfp_pkg::ST_LATCHED;
            next_latched = 1'b1;
          end else begin
            next_st = bfp_pkg::ST_RESTART;
            next_fault_once = 1'b1;
          end
        end else if (hit_clr) begin
          next_fault_once = 1'b0;
        end
      end
      bfp_pkg::ST_RESTART: begin
        if (hit_ar) begin
          next_st = bfp_pkg::ST_ACTIVE;
          next_power_down = 1'b0;
          next_restart_req = 1'b1;
          next_ign_to = 1'b0;
        end
      end
      bfp_pkg::ST_SURGE: begin
        if (!c.bus_voltage_high) begin
          next_st = bfp_pkg::ST_ACTIVE;
          next_power_down = 1'b0;
          next_restart_req = 1'b1;
        end
      end
      bfp_pkg::ST_LATCHED: begin
        next_power_down = 1'b1;
      end
      default: begin
        next_st = bfp_pkg::ST_LATCHED;
        next_power_down = 1'b1;
        next_latched = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= bfp_pkg::ST_ACTIVE;
      power_down <= 1'b0;
      restart_req <= 1'b0;
      latched_fault <= 1'b0;
      ignition_timeout <= 1'b0;
      pfc_off <= 1'b0;
      ignition_ctrl <= 1'b0;
      fault_once <= 1'b0;
    end else begin
      st <= next_st;
      power_down <= next_power_down;
      restart_req <= next_restart_req;
      latched_fault <= next_latched;
      ignition_timeout <= next_ign_to;
      pfc_off <= next_pfc_off;
      ignition_ctrl <= next_ign_ctrl;
      fault_once <= next_fault_once;
    end
  end
endmodule
`default_nettype wire

// >>> tb/bfp_top_properties.sv
// Purpose: Concurrent checks on the fault manager ports
// Assumes: One clock, synchronous active-low reset
// Notes: Filter latency allows for two sync stages and a registered output
`default_nettype none
module bfp_top_properties (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [6:0] mode,
  input wire logic [bfp_pkg::CMP_W-1:0] cmp_in,
  input wire logic power_down,
  input wire logic restart_req,
  input wire logic latched_fault,
  input wire logic ignition_timeout,
  input wire logic pfc_off,
  input wire logic ignition_ctrl,
  input wire logic fault_once
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_pfc_filter: assert property (
    $rose(pfc_off) |-> $past(cmp_in[3], 4) && $past(cmp_in[3], 6)) else $error("pfc early");
  chk_pfc_release: assert property (
    $fell(cmp_in[3]) |-> ##[1:8] !pfc_off) else $error("pfc_off stuck");
  chk_ign_filter: assert property (
    $rose(ignition_ctrl) |-> $past(cmp_in[2], 4) && $past(cmp_in[2], 6)) else $error("ign early");
  chk_ign_mode: assert property (
    ignition_ctrl |-> $past(mode, 2) == bfp_pkg::MODE_IGNITION) else $error("ign mode");
  chk_latch_down: assert property (
    latched_fault |-> power_down && !restart_req) else $error("latched but live");
  chk_latch_second: assert property (
    $rose(latched_fault) |-> $past(fault_once)) else $error("latched on first fault");
  chk_down_until: assert property (
    $fell(power_down) |-> restart_req || $past(restart_req)) else $error("silent restart");
  chk_surge_bus: assert property (
    restart_req && !fault_once |-> !$past(cmp_in[0], 3)) else $error("surge restart high bus");
  // Main scenarios reached
  cover property (pfc_off);
  cover property (ignition_ctrl);
  cover property (restart_req);
endmodule
`default_nettype wire

// >>> tb/bfp_front_model.sv
// Purpose: Comparator front end standing in for the analog sense path
// Assumes: Levels in millivolts and percent of rated bus
// Notes: Gate drives off starve inverter, PFC and lamp sense
`default_nettype none
module bfp_front_model #(
  parameter int INV_LO_MV = 800,
  parameter int INV_HI_MV = 1600,
  parameter int PFC_MV = 1000,
  parameter int BUS_PCT = 109
) (
  input wire logic power_down,
  input var int inv_mv,
  input var int pfc_mv,
  input var int bus_pct,
  input wire logic [3:0] misc,
  output var bfp_pkg::bfp_cmp_t cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Comparators
  // ------------------------------------------------------------
  // Bus stays charged when powered down, so only it survives the gating
  always_comb begin
    cmp = '0;
    if (!power_down) begin
      cmp.inv_cs_low = inv_mv > INV_LO_MV;
      cmp.inv_cs_high = inv_mv > INV_HI_MV;
      cmp.pfc_current_sense = pfc_mv > PFC_MV;
      {cmp.lamp_rectification_fault, cmp.cap_idle, cmp.below_resonance,
        cmp.run_freq_reached} = misc;
    end
    cmp.bus_voltage_high = bus_pct > BUS_PCT;
  end
endmodule
`default_nettype wire

// >>> tb/bfp_top_tb.sv
// Purpose: Self-checking bench for the ballast fault protection manager
// Assumes: Outputs settle one step after the edge
// Notes: Slow-timer restart paths are left to the checker
`default_nettype none
module bfp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Stimulus and checking
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [6:0] mode = 7'h40;
  int inv_mv = 0;
  int pfc_mv = 0;
  int bus_pct = 100;
  logic [3:0] misc = 4'h0;
  logic [31:0] seed = 32'h1f35;
  int err_count = 0;
  int total_checks = 0;
  bfp_pkg::bfp_cmp_t cmp;
  logic power_down, restart_req, latched_fault, ignition_timeout, pfc_off, ignition_ctrl;
  logic fault_once;
  wire logic [6:0] obs = {power_down, restart_req, latched_fault, ignition_timeout, pfc_off,
    ignition_ctrl, fault_once};
  bfp_top uut (.clk(clk), .resetn(resetn), .mode(mode), .cmp_in(cmp), .power_down(power_down),
    .restart_req(restart_req), .latched_fault(latched_fault), .ignition_timeout(ignition_timeout),
    .pfc_off(pfc_off), .ignition_ctrl(ignition_ctrl), .fault_once(fault_once));
  bfp_front_model fe (.power_down(power_down), .inv_mv(inv_mv), .pfc_mv(pfc_mv),
    .bus_pct(bus_pct), .misc(misc), .cmp(cmp));
  // Free-running 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Low inverter threshold holds only in preheat and run
  function automatic logic oc_low(input logic [6:0] m);
    return m == bfp_pkg::MODE_PREHEAT || m == bfp_pkg::MODE_RUN;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic drive(input logic [6:0] m, input int i, input int p, input int b,
    input logic [3:0] f);
    @(posedge clk);
    mode <= m;
    inv_mv <= i;
    pfc_mv <= p;
    bus_pct <= b;
    misc <= f;
  endtask
  // Reset falls on a rising edge like every other input
  task automatic do_reset(input logic [6:0] m);
    drive(m, 0, 0, 100, 4'h0);
    resetn <= 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
  endtask
  // OR of all outputs over n cycles, so a short glitch is not missed
  task automatic watch(input int n, output logic [6:0] acc);
    acc = 7'h00;
    repeat (n) begin
      @(posedge clk);
      #1;
      acc = acc | obs;
    end
  endtask
  // Bounded wait; a lapse counts and ends the run
  task automatic wait_bit(input int idx, input logic v, input int n);
    int k;
    k = 0;
    while (obs[idx] !== v && k < n) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(obs[idx], v);
    if (obs[idx] !== v) begin
      end_sim();
    end
  endtask
  initial begin
    logic [6:0] m;
    logic [6:0] acc;
    do_reset(bfp_pkg::MODE_STARTUP);
    #1;
    chk(obs, 7'h00);
    // PFC limit in every active mode: short spikes ignored, long ones cut on-time
    for (int i = 0; i < 6; i++) begin
      m = 7'h01 << i;
      seed = lfsr(seed);
      drive(m, 0, 1200, 100, 4'h0);
      repeat (seed[1:0]) @(posedge clk);
      drive(m, 0, 0, 100, 4'h0);
      watch(12, acc);
      chk(acc[2], 1'b0);
      drive(m, 0, 1200, 100, 4'h0);
      wait_bit(2, 1'b1, 12);
      watch(int'(seed[5:2]) + 1, acc);
      chk({acc[6], pfc_off}, 2'b01);
      drive(m, 0, 0, 100, 4'h0);
      wait_bit(2, 1'b0, 10);
    end
    // Inverter current: sub-limit bursts, then sustained above each threshold
    for (int i = 0; i < 6; i++) begin
      m = 7'h01 << i;
      do_reset(m);
      repeat (2) begin
        drive(m, 1000, 0, 100, 4'h0);
        watch(10, acc);
        chk(acc[6], 1'b0);
        chk(acc[1], m == bfp_pkg::MODE_IGNITION);
        drive(m, 0, 0, 100, 4'h0);
      end
      drive(m, 1000, 0, 100, 4'h0);
      watch(30, acc);
      chk(acc[6], oc_low(m));
      drive(m, 2000, 0, 100, 4'h0);
      wait_bit(6, 1'b1, 30);
      chk(fault_once, 1'b1);
    end
    // Surge: down without latch, restart only once the bus has fallen
    for (int i = 4; i < 6; i++) begin
      m = 7'h01 << i;
      seed = lfsr(seed);
      do_reset(m);
      drive(m, 1000, 0, 110 + int'(seed[4:0]), 4'h0);
      wait_bit(6, 1'b1, 30);
      chk(fault_once, 1'b0);
      drive(m, 0, 0, 115, 4'h0);
      watch(20, acc);
      chk(acc[5], 1'b0);
      drive(m, 0, 0, 100, 4'h0);
      wait_bit(5, 1'b1, 12);
      @(posedge clk);
      #1;
      chk(power_down, 1'b0);
      chk(restart_req, 1'b0);
    end
    // Below-resonance counts only in run
    for (int i = 4; i < 6; i++) begin
      m = 7'h01 << i;
      do_reset(m);
      drive(m, 0, 0, 100, 4'h2);
      watch(15400, acc);
      chk(acc[6], 1'b0);
      watch(200, acc);
      chk({acc[6], acc[0]}, {2{m == bfp_pkg::MODE_RUN}});
    end
    end_sim();
  end
endmodule
bind bfp_top bfp_top_properties chk_i (.clk(clk), .resetn(resetn), .mode(mode),
  .cmp_in(cmp_in), .power_down(power_down), .restart_req(restart_req),
  .latched_fault(latched_fault), .ignition_timeout(ignition_timeout), .pfc_off(pfc_off),
  .ignition_ctrl(ignition_ctrl), .fault_once(fault_once));
`default_nettype wire
